// [core/uart_shadow_pkg.sv]
package uart_shadow_pkg;
  // Address map of the shadow window and the block's own registers
  localparam logic [31:0] SHADOW_BASE  = 32'h5000_1130;
  localparam int          SHADOW_WORDS = 16;
  localparam logic [31:0] CONTROL_ADDR = 32'h5000_1170;
  localparam logic [31:0] STATUS_ADDR  = 32'h5000_1174;
  localparam logic [15:0] SHADOW_RESET = 16'h0000;

  // Control register fields
  localparam int CTRL_FIFO_EN = 0;
  localparam int CTRL_IR_MODE = 1;

  // Status register fields
  localparam int STAT_RX_VALID = 0;
  localparam int STAT_OVERRUN  = 1;
  localparam int STAT_RX_FULL  = 2;
  localparam int STAT_TX_EMPTY = 5;
  localparam int STAT_TX_FULL  = 6;

  // Timing
  localparam int CLOCK_HZ       = 20_000_000;
  localparam int BAUD_RATE      = 115_200;
  localparam int OVERSAMPLE     = 16;
  localparam int BAUD_DIV       = CLOCK_HZ / (BAUD_RATE * OVERSAMPLE);
  localparam int IR_PULSE_TICKS = 3;
  localparam int FIFO_DEPTH     = 16;

  typedef enum logic [1:0] {
    LINE_IDLE  = 2'b00,
    LINE_START = 2'b01,
    LINE_DATA  = 2'b10,
    LINE_STOP  = 2'b11
  } line_state_type;
endpackage

// [core/byte_stream_if.sv]
`timescale 1ns/100ps
`default_nettype none
// Valid/ready byte stream between the store and the serialiser
interface byte_stream_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface
`default_nettype wire

// [core/two_entry_buffer.sv]
`timescale 1ns/100ps
`default_nettype none
// Two-entry skid buffer; a stall downstream loses no byte
module two_entry_buffer (
  input  wire logic      i_clock, // System clock
  input  wire logic      i_rst,   // Synchronous reset
  byte_stream_if.sink    up,      // Bytes entering
  byte_stream_if.source  down     // Bytes leaving
);
  logic [7:0] slot [2];
  logic       rd_sel;
  logic       wr_sel;
  logic [1:0] fill;

  wire take = up.valid & up.ready;
  wire give = down.valid & down.ready;

  // Handshake terms
  assign up.ready   = (fill != 2'd2);
  assign down.valid = (fill != 2'd0);
  assign down.data  = slot[rd_sel];

  // Slot storage and occupancy
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rd_sel <= 1'b0;
      wr_sel <= 1'b0;
      fill   <= 2'd0;
    end else begin
      if (take) begin
        slot[wr_sel] <= up.data;
        wr_sel       <= ~wr_sel;
      end
      if (give) begin
        rd_sel <= ~rd_sel;
      end
      fill <= fill + {1'b0, take} - {1'b0, give};
    end
  end
endmodule
`default_nettype wire

// [core/uart_shadow_data_port.sv]
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Sixteen word locations all mirror one buffer
// - Read gives received byte, wired or infrared
// - No FIFO: new byte overwrites, flags overrun
// - FIFO on: read returns oldest entry
// - Full FIFO keeps contents, drops byte, overrun
// - Write loads transmit path, wired or infrared
// - No FIFO: idle line takes four writes before holding empty clears
// - No FIFO: further writes replace pending byte
// - FIFO on: idle line accepts depth plus three writes before full
// - Writes into full transmit FIFO are dropped
module uart_shadow_data_port #(
  parameter int FIFO_DEPTH = uart_shadow_pkg::FIFO_DEPTH,
  parameter int BAUD_DIV   = uart_shadow_pkg::BAUD_DIV
) (
  input  wire logic        i_clock,     // 20 MHz clock
  input  wire logic        i_rst,       // Synchronous reset, high
  input  wire logic [31:0] i_paddr,     // APB address
  input  wire logic        i_psel,      // APB select
  input  wire logic        i_penable,   // APB enable
  input  wire logic        i_pwrite,    // APB direction
  input  wire logic [31:0] i_pwdata,    // APB write data
  output logic      [31:0] o_prdata,    // APB read data
  output logic             o_pready,    // APB ready
  output logic             o_pslverr,   // APB error, unmapped
  input  wire logic        i_serial_rx, // Wired serial input
  input  wire logic        i_ir_rx,     // Infrared input, low pulses
  output logic             o_serial_tx, // Wired serial output
  output logic             o_ir_tx_n    // Infrared output, active low
);
  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(FIFO_DEPTH);
  localparam logic [PW-1:0] LAST_P  = PW'(FIFO_DEPTH - 1);
  localparam logic [31:0]   SPAN    = 32'(uart_shadow_pkg::SHADOW_WORDS * 4);
  localparam logic [15:0]   DIV_END = 16'(BAUD_DIV - 1);
  localparam logic [3:0]    LAST_T  = 4'(uart_shadow_pkg::OVERSAMPLE - 1);
  localparam logic [3:0]    MID_T   = 4'(uart_shadow_pkg::OVERSAMPLE / 2 - 1);
  localparam logic [3:0]    IR_T    = 4'(uart_shadow_pkg::IR_PULSE_TICKS);

  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    step = (p == LAST_P) ? '0 : p + 1'b1;
  endfunction

  // Control, status and pin state
  logic       fifo_en;
  logic       ir_mode;
  logic       overrun;
  logic [2:0] rx_sync;
  logic [2:0] ir_sync;
  logic       rx_pin;
  logic       ir_pin;
  logic [15:0] baud_cnt;
  logic        tick;

  // Pins pass three flops; a change counts when the last two agree
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rx_sync <= 3'b111;
      ir_sync <= 3'b111;
      rx_pin  <= 1'b1;
      ir_pin  <= 1'b1;
    end else begin
      rx_sync <= {rx_sync[1:0], i_serial_rx};
      ir_sync <= {ir_sync[1:0], i_ir_rx};
      if (rx_sync[1] == rx_sync[2]) begin
        rx_pin <= rx_sync[2];
      end
      if (ir_sync[1] == ir_sync[2]) begin
        ir_pin <= ir_sync[2];
      end
    end
  end

  // Oversample tick divider
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      baud_cnt <= 16'h0000;
      tick     <= 1'b0;
    end else begin
      tick     <= (baud_cnt == DIV_END);
      baud_cnt <= (baud_cnt == DIV_END) ? 16'h0000 : baud_cnt + 16'h0001;
    end
  end

  // APB decode
  wire [31:0] shadow_off = i_paddr - uart_shadow_pkg::SHADOW_BASE;
  wire hit_shadow = (i_paddr >= uart_shadow_pkg::SHADOW_BASE)
                  && (shadow_off < SPAN) && (i_paddr[1:0] == 2'b00);
  wire hit_ctrl   = (i_paddr == uart_shadow_pkg::CONTROL_ADDR);
  wire hit_status = (i_paddr == uart_shadow_pkg::STATUS_ADDR);
  wire hit_any    = hit_shadow | hit_ctrl | hit_status;
  wire apb_accept = i_psel & i_penable & ~o_pready;
  wire apb_done   = i_psel & i_penable & o_pready;
  wire host_write = apb_done & i_pwrite & hit_shadow;
  wire ctrl_write = apb_done & i_pwrite & hit_ctrl;
  wire stat_read  = apb_accept & ~i_pwrite & hit_status;
  wire mode_flip  = ctrl_write & (i_pwdata[uart_shadow_pkg::CTRL_FIFO_EN] != fifo_en);

  // Receive store
  logic [7:0]    rx_mem [FIFO_DEPTH];
  logic [PW-1:0] rx_rd;
  logic [PW-1:0] rx_wr;
  logic [CW-1:0] rx_count;
  logic          rx_push;
  logic [7:0]    rx_byte;

  wire rx_has   = (rx_count != '0);
  wire rx_pop   = apb_accept & ~i_pwrite & hit_shadow & rx_has;
  wire rx_full  = fifo_en ? (rx_count == DEPTH_C) : rx_has;
  wire rx_block = rx_full & ~rx_pop;
  wire [7:0] rx_head = rx_has ? rx_mem[rx_rd] : 8'h00;

  // Receive store update; overrun on any lost or overwritten byte
  always_ff @(posedge i_clock) begin
    if (i_rst || mode_flip) begin
      rx_rd    <= '0;
      rx_wr    <= '0;
      rx_count <= '0;
    end else begin
      if (rx_push && rx_block && !fifo_en) begin
        rx_mem[rx_rd] <= rx_byte;
      end else if (rx_push && !rx_block) begin
        rx_mem[rx_wr] <= rx_byte;
        rx_wr         <= step(rx_wr);
      end
      if (rx_pop) begin
        rx_rd <= step(rx_rd);
      end
      rx_count <= rx_count + CW'(rx_push && !rx_block) - CW'(rx_pop);
    end
  end

  // Overrun flag: set wins over the clear by a status read
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      overrun <= 1'b0;
    end else if (rx_push && rx_block) begin
      overrun <= 1'b1;
    end else if (stat_read) begin
      overrun <= 1'b0;
    end
  end

  // Transmit store
  byte_stream_if store_out ();
  byte_stream_if line_in ();
  logic [7:0]    tx_mem [FIFO_DEPTH];
  logic [PW-1:0] tx_rd;
  logic [PW-1:0] tx_wr;
  logic [CW-1:0] tx_count;

  wire tx_has   = (tx_count != '0);
  wire tx_empty = ~tx_has;
  wire tx_pop   = store_out.valid & store_out.ready;
  wire tx_full  = fifo_en ? (tx_count == DEPTH_C) : tx_has;
  wire tx_block = tx_full & ~tx_pop;

  assign store_out.valid = tx_has;
  assign store_out.data  = tx_mem[tx_rd];

  // Transmit store update; full writes replace or drop
  always_ff @(posedge i_clock) begin
    if (i_rst || mode_flip) begin
      tx_rd    <= '0;
      tx_wr    <= '0;
      tx_count <= '0;
    end else begin
      if (host_write && tx_block && !fifo_en) begin
        tx_mem[tx_rd] <= i_pwdata[7:0];
      end else if (host_write && !tx_block) begin
        tx_mem[tx_wr] <= i_pwdata[7:0];
        tx_wr         <= step(tx_wr);
      end
      if (tx_pop) begin
        tx_rd <= step(tx_rd);
      end
      tx_count <= tx_count + CW'(host_write && !tx_block) - CW'(tx_pop);
    end
  end

  two_entry_buffer u_tx_buffer (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .up      (store_out),
    .down    (line_in)
  );

  // Read value selection
  wire [31:0] ctrl_value = {30'h0, ir_mode, fifo_en};
  wire [31:0] stat_value = {25'h0, tx_full, tx_empty, 2'b00, rx_full, overrun, rx_has};
  wire [31:0] shad_value = {16'h0, 8'h00, rx_head};
  wire [31:0] read_value = hit_shadow ? shad_value
                         : hit_ctrl   ? ctrl_value
                         : hit_status ? stat_value : 32'h0000_0000;

  // APB answer one cycle into the access phase
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_prdata  <= {16'h0, uart_shadow_pkg::SHADOW_RESET};
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= apb_accept;
      if (apb_accept) begin
        o_prdata  <= i_pwrite ? 32'h0000_0000 : read_value;
        o_pslverr <= ~hit_any;
      end
    end
  end

  // Control register
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      fifo_en <= 1'b0;
      ir_mode <= 1'b0;
    end else if (ctrl_write) begin
      fifo_en <= i_pwdata[uart_shadow_pkg::CTRL_FIFO_EN];
      ir_mode <= i_pwdata[uart_shadow_pkg::CTRL_IR_MODE];
    end
  end

  // Receiver
  uart_shadow_pkg::line_state_type rx_state;
  logic [3:0] rx_tick;
  logic [2:0] rx_bit;
  logic [7:0] rx_shift;
  logic       ir_low_seen;

  wire rx_line = ir_mode ? (ir_pin & ~ir_low_seen) : rx_pin;
  wire rx_sample = tick && (rx_tick == ((rx_state == uart_shadow_pkg::LINE_START) ? MID_T : LAST_T));

  // Infrared zero pulses are caught between two sample points
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ir_low_seen <= 1'b0;
    end else if (!ir_pin) begin
      ir_low_seen <= 1'b1;
    end else if (rx_sample) begin
      ir_low_seen <= 1'b0;
    end
  end

  // Receive frame sequencer
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rx_state <= uart_shadow_pkg::LINE_IDLE;
      rx_tick  <= 4'h0;
      rx_bit   <= 3'h0;
      rx_shift <= 8'h00;
      rx_push  <= 1'b0;
      rx_byte  <= 8'h00;
    end else begin
      rx_push <= 1'b0;
      if (tick && rx_state != uart_shadow_pkg::LINE_IDLE) begin
        rx_tick <= rx_sample ? 4'h0 : rx_tick + 4'h1;
      end
      unique case (rx_state)
        uart_shadow_pkg::LINE_IDLE: begin
          rx_tick <= 4'h0;
          if (!rx_line) begin
            rx_state <= uart_shadow_pkg::LINE_START;
          end
        end
        uart_shadow_pkg::LINE_START: begin
          if (rx_sample) begin
            rx_bit   <= 3'h0;
            rx_state <= rx_line ? uart_shadow_pkg::LINE_IDLE : uart_shadow_pkg::LINE_DATA;
          end
        end
        uart_shadow_pkg::LINE_DATA: begin
          if (rx_sample) begin
            rx_shift <= {rx_line, rx_shift[7:1]};
            rx_bit   <= rx_bit + 3'h1;
            if (rx_bit == 3'h7) begin
              rx_state <= uart_shadow_pkg::LINE_STOP;
            end
          end
        end
        uart_shadow_pkg::LINE_STOP: begin
          if (rx_sample) begin
            rx_push  <= rx_line;
            rx_byte  <= rx_shift;
            rx_state <= uart_shadow_pkg::LINE_IDLE;
          end
        end
      endcase
    end
  end

  // Transmitter
  uart_shadow_pkg::line_state_type tx_state;
  logic [3:0] tx_tick;
  logic [2:0] tx_bit;
  logic [7:0] tx_shift;

  assign line_in.ready = (tx_state == uart_shadow_pkg::LINE_IDLE);
  wire tx_end  = tick && (tx_tick == LAST_T);
  wire tx_line = (tx_state == uart_shadow_pkg::LINE_IDLE) ? 1'b1
               : (tx_state == uart_shadow_pkg::LINE_START) ? 1'b0
               : (tx_state == uart_shadow_pkg::LINE_DATA) ? tx_shift[0] : 1'b1;

  // Transmit frame sequencer
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      tx_state <= uart_shadow_pkg::LINE_IDLE;
      tx_tick  <= 4'h0;
      tx_bit   <= 3'h0;
      tx_shift <= 8'h00;
    end else begin
      if (tick && tx_state != uart_shadow_pkg::LINE_IDLE) begin
        tx_tick <= tx_tick + 4'h1;
      end
      unique case (tx_state)
        uart_shadow_pkg::LINE_IDLE: begin
          tx_tick <= 4'h0;
          if (line_in.valid) begin
            tx_shift <= line_in.data;
            tx_state <= uart_shadow_pkg::LINE_START;
          end
        end
        uart_shadow_pkg::LINE_START: begin
          if (tx_end) begin
            tx_bit   <= 3'h0;
            tx_state <= uart_shadow_pkg::LINE_DATA;
          end
        end
        uart_shadow_pkg::LINE_DATA: begin
          if (tx_end) begin
            tx_shift <= {1'b0, tx_shift[7:1]};
            tx_bit   <= tx_bit + 3'h1;
            if (tx_bit == 3'h7) begin
              tx_state <= uart_shadow_pkg::LINE_STOP;
            end
          end
        end
        uart_shadow_pkg::LINE_STOP: begin
          if (tx_end) begin
            tx_state <= uart_shadow_pkg::LINE_IDLE;
          end
        end
      endcase
    end
  end

  // Output pins: wired line, or short infrared pulse per zero bit
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_serial_tx <= 1'b1;
      o_ir_tx_n   <= 1'b1;
    end else begin
      o_serial_tx <= ir_mode | tx_line;
      o_ir_tx_n   <= ~(ir_mode & ~tx_line & (tx_tick < IR_T));
    end
  end
endmodule
`default_nettype wire

// [dv/uart_shadow_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
// Port-level checks of the shadow data port
module uart_shadow_monitor #(
  parameter int BAUD_DIV = 1
) (
  input wire logic        i_clock,     // Clock
  input wire logic        i_rst,       // Reset
  input wire logic [31:0] i_paddr,     // Address
  input wire logic        i_psel,      // Select
  input wire logic        i_penable,   // Enable
  input wire logic        i_pwrite,    // Direction
  input wire logic [31:0] i_pwdata,    // Write data
  input wire logic [31:0] o_prdata,    // Read data
  input wire logic        o_pready,    // Ready
  input wire logic        o_pslverr,   // Error
  input wire logic        i_serial_rx, // Wired in
  input wire logic        i_ir_rx,     // Infrared in
  input wire logic        o_serial_tx, // Wired out
  input wire logic        o_ir_tx_n    // Infrared out
);
  // Request decode at the accept edge
  wire logic acc = i_psel && i_penable && !o_pready;
  wire logic shd = i_paddr >= uart_shadow_pkg::SHADOW_BASE
                && i_paddr < uart_shadow_pkg::CONTROL_ADDR && i_paddr[1:0] == 2'b00;
  wire logic unm = i_paddr < uart_shadow_pkg::SHADOW_BASE
                || i_paddr > uart_shadow_pkg::STATUS_ADDR;
  wire logic cwr = i_psel && i_penable && o_pready && i_pwrite
                && i_paddr == uart_shadow_pkg::CONTROL_ADDR;
  logic       irm;
  logic       irm_d;
  logic [7:0] low_run;
  // Line mode as written, and length of each infrared low pulse
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      irm     <= 1'b0;
      irm_d   <= 1'b0;
      low_run <= 8'h00;
    end else begin
      if (cwr) irm <= i_pwdata[uart_shadow_pkg::CTRL_IR_MODE];
      irm_d   <= irm;
      low_run <= o_ir_tx_n ? 8'h00 : low_run + 8'h01;
    end
  end
  default clocking dc @(posedge i_clock); endclocking
  default disable iff (i_rst);
  ready_wait_a: assert property (acc |=> o_pready)
    else $error("no ready one cycle after access");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready held too long");
  ready_cause_a: assert property (o_pready |-> $past(acc))
    else $error("ready without access");
  unmapped_err_a: assert property (acc && unm |=> o_pslverr && o_prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  shadow_ok_a: assert property (acc && shd |=> !o_pslverr)
    else $error("shadow access refused");
  upper_zero_a: assert property (acc && shd && !i_pwrite |=> o_prdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  wired_quiet_a: assert property (irm && irm_d |-> o_serial_tx)
    else $error("wired output active in infrared mode");
  ir_quiet_a: assert property (!irm && !irm_d |-> o_ir_tx_n)
    else $error("infrared output active in wired mode");
  ir_pulse_a: assert property ($rose(o_ir_tx_n)
    |-> low_run == 8'(uart_shadow_pkg::IR_PULSE_TICKS * BAUD_DIV))
    else $error("infrared pulse length wrong");
  rd_c: cover property (acc && shd && !i_pwrite);
  wr_c: cover property (acc && shd && i_pwrite);
  err_c: cover property (acc && unm);
  ir_c: cover property ($fell(o_ir_tx_n));
endmodule
bind uart_shadow_data_port uart_shadow_monitor #(.BAUD_DIV(BAUD_DIV)) mon (
  .i_clock(i_clock), .i_rst(i_rst), .i_paddr(i_paddr), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_serial_rx(i_serial_rx),
  .i_ir_rx(i_ir_rx), .o_serial_tx(o_serial_tx), .o_ir_tx_n(o_ir_tx_n));
`default_nettype wire

// [dv/uart_line_partner.sv]
`timescale 1ns/100ps
`default_nettype none
// Far end of the serial and infrared lines
module uart_line_partner #(
  parameter int BAUD_DIV = 1
) (
  input  wire logic i_clock,     // Clock
  input  wire logic i_line_tx,   // Wired from block
  input  wire logic i_line_ir_n, // Infrared from block
  output var  logic o_line_rx,   // Wired to block
  output var  logic o_line_ir    // Infrared to block
);
  localparam int BIT = 16 * BAUD_DIV;
  logic [7:0] seen[$];
  initial o_line_rx = 1'b1;
  initial o_line_ir = 1'b1;
  // Sender: 8N1, LSB first; infrared marks a 0 bit by a short low pulse
  task automatic send(input logic ir, input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      for (int k = 0; k < BIT; k++) begin
        @(posedge i_clock);
        if (ir) o_line_ir <= f[i] || k >= uart_shadow_pkg::IR_PULSE_TICKS * BAUD_DIV;
        else o_line_rx <= f[i];
      end
    end
  endtask
  // Catcher: wired bit read mid-bit, infrared 0 is any low inside the bit
  task automatic watch(input logic ir);
    logic [7:0] b;
    logic       low;
    forever begin
      @(posedge i_clock);
      if ((ir ? i_line_ir_n : i_line_tx) === 1'b0) begin
        // Detection edge counts as the first edge of the start bit
        repeat (BIT - 1) @(posedge i_clock);
        for (int i = 0; i < 8; i++) begin
          low = 1'b0;
          for (int k = 0; k < BIT; k++) begin
            @(posedge i_clock);
            if (ir ? !i_line_ir_n : k == BIT / 2 && !i_line_tx) low = 1'b1;
          end
          b[i] = !low;
        end
        seen.push_back(b);
      end
    end
  endtask
  initial watch(1'b0);
  initial watch(1'b1);
endmodule
`default_nettype wire

// [dv/uart_shadow_data_port_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module uart_shadow_data_port_bench;
  localparam int          FD = 4;
  localparam logic [31:0] CT = uart_shadow_pkg::CONTROL_ADDR;
  localparam logic [31:0] ST = uart_shadow_pkg::STATUS_ADDR;
  logic        clock   = 1'b0;
  logic        rst     = 1'b1;
  logic [31:0] paddr   = 32'h0000_0000;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        stx;
  logic        irtx;
  logic        srx;
  logic        irrx;
  logic        last_err;
  logic [31:0] q;
  int          mismatches;
  int          checks_done;
  int          n;
  // Free-running clock
  always #25 clock = ~clock;
  uart_shadow_data_port #(.FIFO_DEPTH(FD), .BAUD_DIV(1)) dut (
    .i_clock(clock), .i_rst(rst), .i_paddr(paddr), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_serial_rx(srx), .i_ir_rx(irrx), .o_serial_tx(stx),
    .o_ir_tx_n(irtx));
  uart_line_partner #(.BAUD_DIV(1)) partner (
    .i_clock(clock), .i_line_tx(stx), .i_line_ir_n(irtx), .o_line_rx(srx), .o_line_ir(irrx));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer: setup, then access held until ready
  task automatic apb(input logic wr, input logic [31:0] a, d, output logic [31:0] r);
    int k;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      mismatches++;
      tally_and_finish();
    end
    r = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [31:0] a, e, input logic [31:0] m = 32'hFFFF_FFFF);
    logic [31:0] r;
    apb(1'b0, a, 32'h0000_0000, r);
    check(r & m, e);
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  function automatic logic [31:0] sa(input int i);
    return uart_shadow_pkg::SHADOW_BASE + 32'(4 * i);
  endfunction
  // Write bytes until status bit b leaves level lv
  task automatic fill(input int b, input logic lv, input logic [31:0] base);
    n = 0;
    do begin
      wr(sa(n), base + 32'(n));
      n++;
      apb(1'b0, ST, 32'h0000_0000, q);
    end while (q[b] === lv && n < FD + 8);
  endtask
  task automatic wait_line(input int cnt);
    int k;
    k = 0;
    while (partner.seen.size() < cnt && k < 4000) begin
      @(posedge clock);
      k++;
    end
    if (k >= 4000) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 16; i++) rd(sa(i), 32'h0000_0000);
    rd(ST, 32'h0000_0020);
    rd(CT, 32'h0000_0000);
    rd(32'h5000_1200, 32'h0000_0000);
    check({31'h0000_0000, last_err}, 32'h0000_0001);
    $display("reset test done");
    partner.send(1'b0, 8'hA5);
    repeat (4) @(posedge clock);
    rd(ST, 32'h0000_0021, 32'h0000_0063);
    rd(sa(7), 32'h0000_00A5);
    partner.send(1'b0, 8'h11);
    partner.send(1'b0, 8'h22);
    repeat (4) @(posedge clock);
    rd(ST, 32'h0000_0023, 32'h0000_0063);
    rd(sa(15), 32'h0000_0022);
    rd(ST, 32'h0000_0020, 32'h0000_0063);
    $display("receive without fifo done");
    wr(CT, 32'h0000_0001);
    for (int i = 0; i <= FD; i++) partner.send(1'b0, 8'h30 + 8'(i));
    repeat (4) @(posedge clock);
    rd(ST, 32'h0000_0027);
    for (int i = 0; i < FD; i++) rd(sa(i), 32'h0000_0030 + 32'(i));
    rd(ST, 32'h0000_0020);
    wr(CT, 32'h0000_0002);
    partner.send(1'b1, 8'h5C);
    repeat (4) @(posedge clock);
    rd(sa(3), 32'h0000_005C);
    $display("receive with fifo and infrared done");
    wr(CT, 32'h0000_0000);
    partner.seen.delete();
    rd(ST, 32'h0000_0020, 32'h0000_0020);
    fill(5, 1'b1, 32'hFFFF_FF40);
    check(32'(q[5]), 32'h0000_0000);
    wr(sa(9), 32'h0000_004F);
    wait_line(n);
    for (int i = 0; i < n; i++)
      check(32'(partner.seen[i]), i < n - 1 ? 32'h0000_0040 + 32'(i) : 32'h0000_004F);
    wr(CT, 32'h0000_0002);
    partner.seen.delete();
    wr(sa(1), 32'h0000_00B2);
    wait_line(1);
    check(32'(partner.seen[0]), 32'h0000_00B2);
    $display("transmit without fifo done");
    wr(CT, 32'h0000_0001);
    partner.seen.delete();
    fill(6, 1'b0, 32'h0000_0060);
    check(32'(n), 32'(FD + 3));
    wr(sa(2), 32'h0000_00EE);
    wait_line(n);
    repeat (400) @(posedge clock);
    check(32'(partner.seen.size()), 32'(n));
    for (int i = 0; i < n; i++) check(32'(partner.seen[i]), 32'h0000_0060 + 32'(i));
    $display("transmit with fifo done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
